// *** core/frt_pkg.sv ***
// Purpose: Constants for the free-running timer counter
// Assumes: 8-bit register port, one clock
// Notes:   Register offsets are local choices
package frt_pkg;
  localparam logic [15:0] FRT_RESET_COUNT  = 16'hFFFC;
  localparam logic [15:0] FRT_WRITE_COUNT  = 16'hFFFC;
  localparam logic [3:0]  FRT_OFS_CTRL1    = 4'h0;
  localparam logic [3:0]  FRT_OFS_CTRL2    = 4'h1;
  localparam logic [3:0]  FRT_OFS_STATUS   = 4'h2;
  localparam logic [3:0]  FRT_OFS_CNT_HI   = 4'h3;
  localparam logic [3:0]  FRT_OFS_CNT_LO   = 4'h4;
  localparam logic [3:0]  FRT_OFS_ACNT_HI  = 4'h5;
  localparam logic [3:0]  FRT_OFS_ACNT_LO  = 4'h6;
  localparam int          FRT_CTRL1_OVIE   = 5;
  localparam int          FRT_CTRL2_CS0    = 2;
  localparam int          FRT_CTRL2_CS1    = 3;
  localparam int          FRT_CTRL2_EDGE   = 0;
  localparam int          FRT_STATUS_OVF   = 5;
  localparam logic [1:0]  FRT_CS_EXT       = 2'h3;
  localparam logic [1:0]  FRT_CS_DIV2      = 2'h0;
  localparam logic [1:0]  FRT_CS_DIV4      = 2'h1;
  localparam logic [1:0]  FRT_CS_DIV8      = 2'h2;
  localparam logic [7:0]  FRT_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  FRT_READ_UNMAP   = 8'h00;
endpackage

// *** core/frt_timer.sv ***
// Purpose: 16-bit free-running counter with prescaler, external clock,
//          buffered byte reads and overflow flag
// Assumes: CPU register port, one 125 MHz clock
// Notes:   No capture, compare, one-pulse or PWM
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module frt_timer #(
  parameter bit         EXT_PIN_PRESENT = 1'b1,
  parameter logic [1:0] SEL_DIV2        = frt_pkg::FRT_CS_DIV2,
  parameter logic [1:0] SEL_DIV4        = frt_pkg::FRT_CS_DIV4,
  parameter logic [1:0] SEL_DIV8        = frt_pkg::FRT_CS_DIV8
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       ext_clock_pin,
  input  wire logic       cpu_irq_mask,
  input  wire logic       clock_stop_mode,
  output logic            timer_irq,
  output logic      [15:0] count_value
);
  import frt_pkg::*;

  typedef struct packed {
    logic [1:0]  ext_sync;
    logic        ext_last;
    logic [2:0]  presc;
    logic [15:0] count;
    logic [7:0]  lo_buf;
    logic        buf_valid;
    logic        ovf;
    logic        ovf_armed;
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [7:0]  rdata;
  } frt_state_t;

  frt_state_t st_reg;
  frt_state_t st_next;
  // Kept outside the state struct so each variable has a single process driving it
  logic [1:0] rst_sync_reg;
  logic       rst_int_b;
  logic       ext_level;
  logic       ext_sample;
  logic       ext_edge;
  logic       tick;
  logic [1:0] sel;
  logic       lo_primary;
  logic       lo_any;
  logic       hi_any;
  logic       wrap;

  // Two-stage reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_int_b = rst_sync_reg[1];

  // Absent pin reads high; a synchronised level then feeds the edge detector
  assign ext_level = EXT_PIN_PRESENT ? ext_clock_pin : 1'b1;
  assign ext_sample = st_reg.ext_sync[1];
  assign sel = {st_reg.ctrl2[FRT_CTRL2_CS1], st_reg.ctrl2[FRT_CTRL2_CS0]};

  // Edge select: 1 rising, 0 falling
  assign ext_edge = st_reg.ctrl2[FRT_CTRL2_EDGE] ? (ext_sample & ~st_reg.ext_last)
                                                 : (~ext_sample & st_reg.ext_last);

  always_comb begin
    tick = 1'b0;
    if (sel == FRT_CS_EXT) begin
      tick = ext_edge;
    end else if (sel == SEL_DIV2) begin
      tick = (st_reg.presc[0] == 1'b1);
    end else if (sel == SEL_DIV4) begin
      tick = (st_reg.presc[1:0] == 2'h3);
    end else if (sel == SEL_DIV8) begin
      tick = (st_reg.presc == 3'h7);
    end
  end

  assign hi_any     = rd && (addr == FRT_OFS_CNT_HI || addr == FRT_OFS_ACNT_HI);
  assign lo_primary = (rd || wr) && addr == FRT_OFS_CNT_LO;
  assign lo_any     = (rd || wr) && (addr == FRT_OFS_CNT_LO || addr == FRT_OFS_ACNT_LO);
  assign wrap       = tick && !clock_stop_mode && st_reg.count == 16'hFFFF;

  always_comb begin
    st_next          = st_reg;
    st_next.ext_sync = {st_reg.ext_sync[0], ext_level};
    st_next.ext_last = ext_sample;
    // Wait mode has no input here, so counting never pauses for it
    if (!clock_stop_mode) begin
      st_next.presc = st_reg.presc + 3'h1;
      if (tick) begin
        st_next.count = st_reg.count + 16'h0001;
      end
    end
    if (wr && (addr == FRT_OFS_CNT_LO || addr == FRT_OFS_ACNT_LO)) begin
      st_next.count = FRT_WRITE_COUNT;
      st_next.presc = 3'h0;
    end
    if (wr && addr == FRT_OFS_CTRL1) begin
      st_next.ctrl1 = wdata;
    end
    if (wr && addr == FRT_OFS_CTRL2) begin
      st_next.ctrl2 = wdata;
    end
    // Read path; data lands one cycle after the strobe
    st_next.rdata = FRT_READ_UNMAP;
    if (rd) begin
      unique case (addr)
        FRT_OFS_CTRL1:  st_next.rdata = st_reg.ctrl1;
        FRT_OFS_CTRL2:  st_next.rdata = st_reg.ctrl2;
        FRT_OFS_STATUS: st_next.rdata = {2'h0, st_reg.ovf, 5'h00};
        FRT_OFS_CNT_HI, FRT_OFS_ACNT_HI: begin
          st_next.rdata = st_reg.count[15:8];
          if (!st_reg.buf_valid) begin
            st_next.lo_buf    = st_reg.count[7:0];
            st_next.buf_valid = 1'b1;
          end
        end
        FRT_OFS_CNT_LO, FRT_OFS_ACNT_LO: begin
          st_next.rdata     = st_reg.buf_valid ? st_reg.lo_buf : st_reg.count[7:0];
          st_next.buf_valid = 1'b0;
        end
        default: st_next.rdata = FRT_READ_UNMAP;
      endcase
    end
    // Overflow flag: arm on status read while set, clear on primary low access
    if (rd && addr == FRT_OFS_STATUS && st_reg.ovf) begin
      st_next.ovf_armed = 1'b1;
    end
    if (lo_primary && st_reg.ovf_armed) begin
      st_next.ovf       = 1'b0;
      st_next.ovf_armed = 1'b0;
    end
    // Set beats clear in the same cycle
    if (wrap) begin
      st_next.ovf       = 1'b1;
      st_next.ovf_armed = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      st_reg.ext_sync  <= 2'h3;
      st_reg.ext_last  <= 1'b1;
      st_reg.presc     <= 3'h0;
      st_reg.count     <= FRT_RESET_COUNT;
      st_reg.lo_buf    <= 8'h00;
      st_reg.buf_valid <= 1'b0;
      st_reg.ovf       <= 1'b0;
      st_reg.ovf_armed <= 1'b0;
      st_reg.ctrl1     <= FRT_CTRL_RESET;
      st_reg.ctrl2     <= FRT_CTRL_RESET;
      st_reg.rdata     <= 8'h00;
    end else begin
      st_reg.ext_sync  <= st_next.ext_sync;
      st_reg.ext_last  <= st_next.ext_last;
      st_reg.presc     <= st_next.presc;
      st_reg.count     <= st_next.count;
      st_reg.lo_buf    <= st_next.lo_buf;
      st_reg.buf_valid <= st_next.buf_valid;
      st_reg.ovf       <= st_next.ovf;
      st_reg.ovf_armed <= st_next.ovf_armed;
      st_reg.ctrl1     <= st_next.ctrl1;
      st_reg.ctrl2     <= st_next.ctrl2;
      st_reg.rdata     <= st_next.rdata;
    end
  end

  // Single clock domain: external edges are resolved on rising CPU edges,
  // two cycles late, standing in for the falling-edge update
  assign count_value = st_reg.count;
  assign rdata       = st_reg.rdata;
  // Pending request persists until the overflow flag clears, and is hidden while the mask is set
  assign timer_irq = st_reg.ovf && st_reg.ctrl1[FRT_CTRL1_OVIE] && !cpu_irq_mask;

  a_write_loads: assert property (@(posedge clk) disable iff (!rst_int_b)
    wr && (addr == FRT_OFS_CNT_LO || addr == FRT_OFS_ACNT_LO) |=> st_reg.count == 16'hFFFC)
    else $error("low write did not load FFFC");

  a_alt_keeps_flag: assert property (@(posedge clk) disable iff (!rst_int_b)
    rd && addr == FRT_OFS_ACNT_LO && st_reg.ovf && !wrap |=> st_reg.ovf)
    else $error("alternate low read cleared flag");

  a_hi_returns: assert property (@(posedge clk) disable iff (!rst_int_b)
    hi_any |=> rdata == $past(st_reg.count[15:8]))
    else $error("high byte read wrong");

  a_wrap_sets_flag: assert property (@(posedge clk) disable iff (!rst_int_b)
    wrap |=> st_reg.ovf && st_reg.count == 16'h0000)
    else $error("wrap did not set flag");

  a_irq_gating: assert property (@(posedge clk) disable iff (!rst_int_b)
    timer_irq |-> st_reg.ovf && st_reg.ctrl1[FRT_CTRL1_OVIE] && !cpu_irq_mask)
    else $error("interrupt without cause");

  a_irq_pending: assert property (@(posedge clk) disable iff (!rst_int_b)
    st_reg.ovf && st_reg.ctrl1[FRT_CTRL1_OVIE] && !cpu_irq_mask |-> timer_irq)
    else $error("pending interrupt not raised");

  a_flag_clear_seq: assert property (@(posedge clk) disable iff (!rst_int_b)
    $fell(st_reg.ovf) |-> $past(lo_primary) && $past(st_reg.ovf_armed))
    else $error("flag cleared without sequence");

  a_stop_holds: assert property (@(posedge clk) disable iff (!rst_int_b)
    clock_stop_mode && !(wr && lo_any) |=> $stable(st_reg.count))
    else $error("counter moved while stopped");

  a_stop_presc: assert property (@(posedge clk) disable iff (!rst_int_b)
    clock_stop_mode && !wr |=> $stable(st_reg.presc))
    else $error("prescaler moved while stopped");

  a_wait_runs: assert property (@(posedge clk) disable iff (!rst_int_b)
    !clock_stop_mode && !(wr && lo_any) |=> st_reg.presc == $past(st_reg.presc) + 3'h1)
    else $error("prescaler paused while running");

  a_buffer_frozen: assert property (@(posedge clk) disable iff (!rst_int_b)
    st_reg.buf_valid && !(rd && (addr == FRT_OFS_CNT_LO || addr == FRT_OFS_ACNT_LO))
      |=> st_reg.buf_valid && $stable(st_reg.lo_buf))
    else $error("buffered low byte changed");

  a_hi_captures: assert property (@(posedge clk) disable iff (!rst_int_b)
    hi_any && !st_reg.buf_valid |=> st_reg.lo_buf == $past(st_reg.count[7:0]))
    else $error("high read did not capture low");

  a_low_gives_buf: assert property (@(posedge clk) disable iff (!rst_int_b)
    rd && (addr == FRT_OFS_CNT_LO || addr == FRT_OFS_ACNT_LO) && st_reg.buf_valid
      |=> rdata == $past(st_reg.lo_buf) && !st_reg.buf_valid)
    else $error("low read missed buffered byte");

  a_lone_low_live: assert property (@(posedge clk) disable iff (!rst_int_b)
    rd && (addr == FRT_OFS_CNT_LO || addr == FRT_OFS_ACNT_LO) && !st_reg.buf_valid
      |=> rdata == $past(st_reg.count[7:0]))
    else $error("lone low read not live");

  a_count_step: assert property (@(posedge clk) disable iff (!rst_int_b)
    tick && !clock_stop_mode && !(wr && lo_any) |=> st_reg.count == $past(st_reg.count) + 16'h0001)
    else $error("counter did not step by one");

  a_count_idle: assert property (@(posedge clk) disable iff (!rst_int_b)
    !tick && !(wr && lo_any) |=> $stable(st_reg.count))
    else $error("counter moved without tick");

  a_div2_rate: assert property (@(posedge clk) disable iff (!rst_int_b)
    sel == SEL_DIV2 && tick && !clock_stop_mode && !wr |=> !tick)
    else $error("divide by 2 rate wrong");

  a_div4_rate: assert property (@(posedge clk) disable iff (!rst_int_b)
    sel == SEL_DIV4 && tick && !clock_stop_mode && !wr |=> !tick)
    else $error("divide by 4 rate wrong");

  a_div8_rate: assert property (@(posedge clk) disable iff (!rst_int_b)
    sel == SEL_DIV8 && tick && !clock_stop_mode && !wr |=> !tick)
    else $error("divide by 8 rate wrong");

  a_ext_only_edges: assert property (@(posedge clk) disable iff (!rst_int_b)
    sel == FRT_CS_EXT && !ext_edge |-> !tick)
    else $error("external mode ticked without edge");

  a_reset_state: assert property (@(posedge clk) disable iff (!rst_int_b)
    $rose(rst_int_b) |-> st_reg.count == FRT_RESET_COUNT && !st_reg.ovf && !st_reg.ctrl1[FRT_CTRL1_OVIE])
    else $error("reset state wrong");

  c_wrap: cover property (@(posedge clk) disable iff (!rst_int_b) wrap);
  c_irq: cover property (@(posedge clk) disable iff (!rst_int_b) timer_irq);
  c_clear: cover property (@(posedge clk) disable iff (!rst_int_b) $fell(st_reg.ovf));
  c_ext: cover property (@(posedge clk) disable iff (!rst_int_b) sel == FRT_CS_EXT && tick);
  c_buffered: cover property (@(posedge clk) disable iff (!rst_int_b) rd && lo_any && st_reg.buf_valid);
endmodule

// *** verification/frt_ext_src.sv ***
// Purpose: External count clock source
// Assumes: Pin sampled by the timer clock
// Notes:   Levels held long, edges never crowd
`timescale 1ns/1ps
module frt_ext_src (
  input  wire logic clk,
  output logic      pin
);
  initial pin = 1'b0;
  // Eight cycles per level, well past the four-edge minimum
  task automatic set_level(input logic v);
    @(posedge clk);
    pin <= v;
    repeat (8) @(posedge clk);
  endtask
endmodule

// *** verification/frt_tb.sv ***
// Purpose: Self-checking bench for the timer counter
// Assumes: Stop mode used to freeze counts for exact reads
// Notes:   Read results checked from a queue a cycle later
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; $display("wrong value %s %h %h", n, e, s); end end
module testbench;
  import frt_pkg::*;
  logic        clk;
  logic        rst_b;
  logic [3:0]  addr;
  logic [3:0]  hi;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  e8;
  logic [7:0]  exp_q[$];
  logic        wr;
  logic        rd;
  logic        ext_pin;
  logic        irq_mask;
  logic        stop;
  logic        timer_irq;
  logic        rd_seen;
  logic [15:0] count_value;
  logic [15:0] a;
  logic [15:0] v;
  logic [1:0]  sel[3];
  int          n_mismatch;
  int          cmp_count;
  int          cycles;
  int          seed;

  frt_timer u_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_clock_pin(ext_pin), .cpu_irq_mask(irq_mask), .clock_stop_mode(stop),
    .timer_irq(timer_irq), .count_value(count_value));
  frt_ext_src u_src (.clk(clk), .pin(ext_pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    cycles++;
    if (rd_seen) begin
      e8 = exp_q.pop_front();
      `CHK("rdata", e8, rdata)
    end
    rd_seen = rd;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] ad, input logic [7:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic cnt(input logic [15:0] e);
    @(negedge clk);
    `CHK("count", e, count_value)
  endtask

  // Extra edge lets the hold settle before sampling
  task automatic halt(input logic s);
    @(posedge clk);
    stop <= s;
    repeat (2) @(posedge clk);
    @(negedge clk);
    a = count_value;
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    seed = 78274;
    sel = '{FRT_CS_DIV2, FRT_CS_DIV4, FRT_CS_DIV8};
    {rst_b, wr, rd, stop, rd_seen, wdata, addr} = '0;
    irq_mask = 1'b1;
    n_mismatch = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    cnt(FRT_RESET_COUNT);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rd_reg(FRT_OFS_STATUS, 8'h00);
    rd_reg(FRT_OFS_CTRL1, FRT_CTRL_RESET);
    rd_reg(4'hF, FRT_READ_UNMAP);
    for (int i = 0; i < 3; i++) begin
      wr_reg(FRT_OFS_CTRL2, {4'h0, sel[i], 2'h0});
      halt(1'b0);
      repeat (63) @(negedge clk);
      cnt(a + 16'(64 >> (i + 1)));
    end
    halt(1'b1);
    repeat (31) @(negedge clk);
    cnt(a);
    halt(1'b0);
    repeat (63) @(negedge clk);
    cnt(a + 16'h0008);
    wr_reg(FRT_OFS_CTRL2, 8'h00);
    for (int b = 0; b < 2; b++) begin
      hi = b ? FRT_OFS_ACNT_HI : FRT_OFS_CNT_HI;
      halt(1'b1);
      v = a;
      rd_reg(hi, v[15:8]);
      halt(1'b0);
      repeat (40) @(posedge clk);
      halt(1'b1);
      rd_reg(hi, a[15:8]);
      rd_reg(hi + 4'h1, v[7:0]);
      rd_reg(hi + 4'h1, a[7:0]);
    end
    halt(1'b0);
    rd_reg(FRT_OFS_STATUS, 8'h20);
    wr_reg(FRT_OFS_ACNT_LO, 8'($random(seed)));
    cnt(FRT_WRITE_COUNT);
    wr_reg(FRT_OFS_CNT_LO, 8'($random(seed)));
    cnt(FRT_WRITE_COUNT);
    rd_reg(FRT_OFS_STATUS, 8'h00);
    wr_reg(FRT_OFS_CTRL1, 8'h20);
    repeat (20) @(negedge clk);
    `CHK("irq", 1'b0, timer_irq)
    irq_mask <= 1'b0;
    halt(1'b1);
    `CHK("irq", 1'b1, timer_irq)
    rd_reg(FRT_OFS_CNT_LO, a[7:0]);
    rd_reg(FRT_OFS_STATUS, 8'h20);
    rd_reg(FRT_OFS_ACNT_LO, a[7:0]);
    rd_reg(FRT_OFS_STATUS, 8'h20);
    rd_reg(FRT_OFS_CNT_LO, a[7:0]);
    rd_reg(FRT_OFS_STATUS, 8'h00);
    `CHK("irq", 1'b0, timer_irq)
    wr_reg(FRT_OFS_CTRL2, 8'h0D);
    halt(1'b0);
    u_src.set_level(1'b1);
    cnt(a + 16'h0001);
    u_src.set_level(1'b0);
    cnt(a + 16'h0001);
    wr_reg(FRT_OFS_CTRL2, 8'h0C);
    u_src.set_level(1'b1);
    cnt(a + 16'h0001);
    u_src.set_level(1'b0);
    cnt(a + 16'h0002);
    close_out();
  end
endmodule
